/* src/dlmsc_mode_sleep_ctrl.sv */
// Role straps, multiplier select, power-up, sleep and error flag control
`timescale 1ns/1ns
module dlmsc_mode_sleep_ctrl #(
  parameter int unsigned KEEP_OFF_EDGES = dlmsc_pkg::KEEP_OFF_EDGES,
  parameter int unsigned STOP_CYCLES = dlmsc_pkg::CLK_STOP_CYCLES
) (
  input logic CLK_IN,
  input logic RESET_IN,
  input logic MASTER_SLAVE_SELECT_IN,
  input logic FACTORY_TEST_SELECT_IN,
  input logic [1:0] PLL_MULTIPLIER_SELECT_IN,
  input logic POWER_DOWN_N_IN,
  input logic WRITE_ONLY_SELECT_IN,
  input logic [1:0] OUTPUT_DRIVE_SELECT_IN,
  input logic REF_CLOCK_IN,
  input logic SERIAL_LINK_CLOCK_IN,
  input logic PLL_LOCKED_IN,
  input logic HOST_MAIN_DISPLAY_SELECT_N_IN,
  input logic HOST_SUB_DISPLAY_SELECT_N_IN,
  input logic HOST_WRITE_N_IN,
  input logic HOST_READ_N_IN,
  input logic READ_CRC_ERROR_IN,
  input logic READ_COLLECT_IN,
  input logic LINK_CRC_ERROR_IN,
  input logic [dlmsc_pkg::DISP_W-1:0] ENG_DATA_IN,
  input logic ENG_DATA_RELEASE_IN,
  input logic ENG_MAIN_DISPLAY_SELECT_N_IN,
  input logic ENG_SUB_DISPLAY_SELECT_N_IN,
  input logic ENG_WRITE_N_IN,
  input logic ENG_READ_N_IN,
  input logic ENG_COMMAND_DATA_IN,
  output logic ROLE_MASTER_OUT,
  output logic TEST_MODE_OUT,
  output logic SLEEP_OUT,
  output logic LINK_READY_OUT,
  output logic PLL_ENABLE_OUT,
  output logic [dlmsc_pkg::FACTOR_W-1:0] PLL_FACTOR_OUT,
  output logic [dlmsc_pkg::LINE_W-1:0] LINE_RATE_FACTOR_OUT,
  output logic CONFIG_FAULT_OUT,
  output logic HOST_INPUTS_ACTIVE_OUT,
  output logic HOST_WRITE_REQ_OUT,
  output logic HOST_READ_REQ_OUT,
  output logic HOST_SUB_SELECT_OUT,
  output logic READ_PERMIT_OUT,
  output logic DATA_EDGE_SOFT_OUT,
  output logic STROBE_EDGE_SOFT_OUT,
  output logic ERROR_FLAG_OUT,
  output logic [dlmsc_pkg::DISP_W-1:0] DISP_DATA_OUT,
  output logic DISP_DATA_OE_N_OUT,
  output logic DISP_MAIN_SELECT_N_OUT,
  output logic DISP_SUB_SELECT_N_OUT,
  output logic DISP_WRITE_N_OUT,
  output logic DISP_READ_N_OUT,
  output logic DISP_COMMAND_DATA_OUT
);
  import dlmsc_pkg::*;

  typedef struct packed {
    logic [IN_W-1:0] sy1;
    logic [IN_W-1:0] sy2;
    logic [1:0] strobe_prev;
    logic [1:0] settle;
    logic taken;
    logic master;
    logic test;
    logic [1:0] pll_sel;
    dlmsc_state_e state;
    logic restart;
    logic ms_err;
    logic sl_err;
    logic pll_en;
    logic [FACTOR_W-1:0] factor;
    logic [LINE_W-1:0] line_factor;
    logic cfg_fault;
    logic ready;
    logic sleep;
    logic host_active;
    logic wr_req;
    logic rd_req;
    logic sub_sel;
    logic read_permit;
    logic data_soft;
    logic strobe_soft;
    logic err_out;
    logic [DISP_W-1:0] disp_data;
    logic disp_oe_n;
    logic main_n;
    logic sub_n;
    logic wr_n;
    logic rd_n;
    logic cd;
  } dlmsc_ctrl_s;

  dlmsc_ctrl_s r;
  dlmsc_ctrl_s n;
  logic [IN_W-1:0] pins;
  logic watch_pin;
  logic pd_n;
  logic reserved;
  logic awake;
  logic ready_n;
  logic cs_hit;

  dlmsc_clk_if ck_if (.clk(CLK_IN), .rst(RESET_IN));

  // Master watches its reference, slave watches the link clock
  assign watch_pin = r.master ? REF_CLOCK_IN : SERIAL_LINK_CLOCK_IN;
  assign ck_if.restart = r.restart;
  assign pins = {PLL_LOCKED_IN, HOST_READ_N_IN, HOST_WRITE_N_IN,
    HOST_SUB_DISPLAY_SELECT_N_IN, HOST_MAIN_DISPLAY_SELECT_N_IN,
    OUTPUT_DRIVE_SELECT_IN, WRITE_ONLY_SELECT_IN, POWER_DOWN_N_IN,
    PLL_MULTIPLIER_SELECT_IN, FACTORY_TEST_SELECT_IN, MASTER_SLAVE_SELECT_IN};

  dlmsc_clk_watch #(.STOP_CYCLES(STOP_CYCLES)) u_watch (
    .clk_pin_in(watch_pin),
    .bus(ck_if)
  );

  dlmsc_keep_off #(.EDGES(KEEP_OFF_EDGES)) u_keep_off (
    .bus(ck_if)
  );

  always_comb
  begin
    n = r;
    n.sy1 = pins;
    n.sy2 = r.sy1;
    n.strobe_prev = {r.sy2[IN_RD_N], r.sy2[IN_WR_N]};
    n.restart = 1'b0;
    pd_n = r.sy2[IN_PD_N];
    reserved = (dlmsc_factor(r.pll_sel) == FACTOR_NONE);
    // Straps caught once the synchronisers have settled
    if (!r.taken)
    begin
      n.settle = r.settle + 2'h1;
      if (r.settle == 2'(STRAP_SETTLE))
      begin
        n.taken = 1'b1;
        n.master = r.sy2[IN_ROLE];
        n.test = r.sy2[IN_TEST];
        n.pll_sel = r.sy2[IN_PLL1:IN_PLL0];
      end
    end
    case (r.state)
      ST_SLEEP:
      begin
        if (r.taken && r.test)
          n.state = ST_TEST;
        else if (r.taken && pd_n && !ck_if.stopped)
        begin
          if (!r.master)
            n.state = ST_READY;
          else if (!reserved)
          begin
            n.state = ST_WAIT_LOCK;
            n.restart = 1'b1;
          end
        end
      end
      ST_WAIT_LOCK:
      begin
        if (!pd_n || ck_if.stopped)
          n.state = ST_SLEEP;
        else if (ck_if.ready && r.sy2[IN_LOCK] && !r.restart)
          n.state = ST_READY;
      end
      ST_READY:
      begin
        if (!pd_n || ck_if.stopped)
          n.state = ST_SLEEP;
      end
      ST_TEST:
        n.state = ST_TEST;
      default:
        n.state = ST_SLEEP;
    endcase
    awake = (n.state == ST_WAIT_LOCK) || (n.state == ST_READY);
    ready_n = (n.state == ST_READY);
    // Error flags; a new error wins over a clear in the same cycle
    n.ms_err = r.master && ready_n &&
      (READ_CRC_ERROR_IN || (r.ms_err && !READ_COLLECT_IN));
    n.sl_err = !r.master &&
      ((LINK_CRC_ERROR_IN && (r.state == ST_READY)) || (r.sl_err && pd_n));
    n.err_out = ready_n && (r.master ? n.ms_err : n.sl_err);
    // Host cycles count only with a chip select and a ready link
    cs_hit = !r.sy2[IN_CS1_N] || !r.sy2[IN_CS2_N];
    n.wr_req = r.master && (r.state == ST_READY) && cs_hit &&
      r.strobe_prev[0] && !r.sy2[IN_WR_N];
    n.rd_req = r.master && (r.state == ST_READY) && cs_hit &&
      r.strobe_prev[1] && !r.sy2[IN_RD_N];
    n.sub_sel = cs_hit ? r.sy2[IN_CS1_N] : r.sub_sel;
    n.factor = r.master ? dlmsc_factor(r.pll_sel) : FACTOR_NONE;
    n.line_factor = LINE_W'(n.factor * BITS_PER_LINK_CLOCK);
    n.cfg_fault = r.taken && r.master && reserved;
    n.pll_en = r.master && awake;
    n.ready = ready_n;
    n.sleep = (n.state == ST_SLEEP);
    n.host_active = r.master && awake;
    n.read_permit = !r.master && ready_n && !r.sy2[IN_WO];
    n.data_soft = !r.master && !r.sy2[IN_ODS0];
    n.strobe_soft = !r.master && !r.sy2[IN_ODS1];
    if (!r.master && ready_n)
    begin
      n.disp_data = ENG_DATA_IN;
      n.disp_oe_n = ENG_DATA_RELEASE_IN && !r.sy2[IN_WO];
      n.main_n = ENG_MAIN_DISPLAY_SELECT_N_IN;
      n.sub_n = ENG_SUB_DISPLAY_SELECT_N_IN;
      n.wr_n = ENG_WRITE_N_IN;
      n.rd_n = ENG_READ_N_IN || r.sy2[IN_WO];
      n.cd = ENG_COMMAND_DATA_IN;
    end
    else
    begin
      n.disp_data = DISP_DATA_IDLE;
      n.disp_oe_n = 1'b0;
      n.main_n = STROBE_IDLE;
      n.sub_n = STROBE_IDLE;
      n.wr_n = STROBE_IDLE;
      n.rd_n = STROBE_IDLE;
      n.cd = STROBE_IDLE;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      r <= '0;
      r.strobe_prev <= 2'h3;
      r.sleep <= 1'b1;
      r.err_out <= ERR_IDLE;
      r.main_n <= STROBE_IDLE;
      r.sub_n <= STROBE_IDLE;
      r.wr_n <= STROBE_IDLE;
      r.rd_n <= STROBE_IDLE;
      r.cd <= STROBE_IDLE;
    end
    else
      r <= n;
  end

  assign ROLE_MASTER_OUT = r.master;
  assign TEST_MODE_OUT = r.test;
  assign SLEEP_OUT = r.sleep;
  assign LINK_READY_OUT = r.ready;
  assign PLL_ENABLE_OUT = r.pll_en;
  assign PLL_FACTOR_OUT = r.factor;
  assign LINE_RATE_FACTOR_OUT = r.line_factor;
  assign CONFIG_FAULT_OUT = r.cfg_fault;
  assign HOST_INPUTS_ACTIVE_OUT = r.host_active;
  assign HOST_WRITE_REQ_OUT = r.wr_req;
  assign HOST_READ_REQ_OUT = r.rd_req;
  assign HOST_SUB_SELECT_OUT = r.sub_sel;
  assign READ_PERMIT_OUT = r.read_permit;
  assign DATA_EDGE_SOFT_OUT = r.data_soft;
  assign STROBE_EDGE_SOFT_OUT = r.strobe_soft;
  assign ERROR_FLAG_OUT = r.err_out;
  assign DISP_DATA_OUT = r.disp_data;
  assign DISP_DATA_OE_N_OUT = r.disp_oe_n;
  assign DISP_MAIN_SELECT_N_OUT = r.main_n;
  assign DISP_SUB_SELECT_N_OUT = r.sub_n;
  assign DISP_WRITE_N_OUT = r.wr_n;
  assign DISP_READ_N_OUT = r.rd_n;
  assign DISP_COMMAND_DATA_OUT = r.cd;

  AST_SLEEP_ERR_LOW: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.state != ST_READY) |-> (ERROR_FLAG_OUT == ERR_IDLE))
    else $error("error flag high outside operation");
  AST_SLAVE_SLEEP_LEVELS: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (!r.master && r.state == ST_SLEEP) |->
      (DISP_DATA_OUT == DISP_DATA_IDLE && DISP_MAIN_SELECT_N_OUT && DISP_SUB_SELECT_N_OUT
      && DISP_WRITE_N_OUT && DISP_READ_N_OUT && DISP_COMMAND_DATA_OUT && !DISP_DATA_OE_N_OUT))
    else $error("slave sleep levels wrong");
  AST_PLL_MASTER_ONLY: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    PLL_ENABLE_OUT |-> (r.master && !r.cfg_fault && r.state != ST_SLEEP))
    else $error("PLL enabled outside awake master");
  AST_READY_AFTER_KEEPOFF: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ($rose(LINK_READY_OUT) && r.master) |-> ($past(ck_if.ready) && $past(r.sy2[IN_LOCK])))
    else $error("master ready before lock and keep-off");
  AST_WAKE_RESTART: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.state == ST_SLEEP ##1 r.state == ST_WAIT_LOCK) |-> (r.restart ##1 !ck_if.ready))
    else $error("wake without keep-off restart");
  AST_PD_SLEEPS: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (!r.sy2[IN_PD_N] && r.state != ST_TEST && !r.test) |=> (r.state == ST_SLEEP && SLEEP_OUT))
    else $error("power-down low did not sleep");
  AST_STOP_SLEEPS: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (ck_if.stopped && r.master && r.state != ST_TEST && !r.test) |=> (r.state == ST_SLEEP))
    else $error("stopped reference did not sleep");
  AST_SLAVE_ERR_STICKY: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.sl_err && r.sy2[IN_PD_N]) |=> r.sl_err)
    else $error("slave error cleared without power-down");
  AST_WRITE_ONLY: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (r.sy2[IN_WO] && !r.master) |=> (DISP_READ_N_OUT && !READ_PERMIT_OUT && !DISP_DATA_OE_N_OUT))
    else $error("read activity in write-only mode");
  AST_HOST_SELECTED: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (HOST_WRITE_REQ_OUT || HOST_READ_REQ_OUT) |->
      ($past(!r.sy2[IN_CS1_N] || !r.sy2[IN_CS2_N]) && $past(r.state) == ST_READY))
    else $error("host request without chip select or ready link");
endmodule : dlmsc_mode_sleep_ctrl

/* src/dlmsc_pkg.sv */
// Shared constants, types and decode for the link mode and sleep controller
package dlmsc_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_STOP_NS = 2000;
  localparam int unsigned CLK_STOP_CYCLES = (CLK_STOP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned KEEP_OFF_EDGES = 1024;
  localparam int unsigned LINK_CLOCK_MAX_MHZ = 240;
  localparam int unsigned BITS_PER_LINK_CLOCK = 2;
  localparam int unsigned STRAP_SETTLE = 3;
  localparam int unsigned DISP_W = 18;
  localparam int unsigned FACTOR_W = 4;
  localparam int unsigned LINE_W = 5;
  localparam logic [1:0] PLL_SEL_X8 = 2'h0;
  localparam logic [1:0] PLL_SEL_X10 = 2'h1;
  localparam logic [1:0] PLL_SEL_X12 = 2'h2;
  localparam logic [1:0] PLL_SEL_RSVD = 2'h3;
  localparam logic [3:0] FACTOR_X8 = 4'h8;
  localparam logic [3:0] FACTOR_X10 = 4'hA;
  localparam logic [3:0] FACTOR_X12 = 4'hC;
  localparam logic [3:0] FACTOR_NONE = 4'h0;
  localparam logic [17:0] DISP_DATA_IDLE = 18'h00000;
  localparam logic STROBE_IDLE = 1'h1;
  localparam logic ERR_IDLE = 1'h0;
  // Bit positions of the synchronised pin vector
  localparam int unsigned IN_ROLE = 0;
  localparam int unsigned IN_TEST = 1;
  localparam int unsigned IN_PLL0 = 2;
  localparam int unsigned IN_PLL1 = 3;
  localparam int unsigned IN_PD_N = 4;
  localparam int unsigned IN_WO = 5;
  localparam int unsigned IN_ODS0 = 6;
  localparam int unsigned IN_ODS1 = 7;
  localparam int unsigned IN_CS1_N = 8;
  localparam int unsigned IN_CS2_N = 9;
  localparam int unsigned IN_WR_N = 10;
  localparam int unsigned IN_RD_N = 11;
  localparam int unsigned IN_LOCK = 12;
  localparam int unsigned IN_W = 13;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_WAIT_LOCK = 2'b01,
    ST_READY = 2'b10,
    ST_TEST = 2'b11
  } dlmsc_state_e;

  function automatic logic [3:0] dlmsc_factor(input logic [1:0] sel);
    logic [3:0] f;
    case (sel)
      PLL_SEL_X8: f = FACTOR_X8;
      PLL_SEL_X10: f = FACTOR_X10;
      PLL_SEL_X12: f = FACTOR_X12;
      default: f = FACTOR_NONE;
    endcase
    return f;
  endfunction : dlmsc_factor
endpackage : dlmsc_pkg

/* src/dlmsc_clk_if.sv */
// Clock watch and keep-off counter signals
`timescale 1ns/1ns
interface dlmsc_clk_if (
  input logic clk,
  input logic rst
);
  logic edge_seen;
  logic stopped;
  logic restart;
  logic ready;
  modport watch (input clk, input rst, output edge_seen, output stopped);
  modport count (input clk, input rst, input edge_seen, input restart, output ready);
endinterface : dlmsc_clk_if

/* src/dlmsc_clk_watch.sv */
// Samples an outside clock pin, flags its rising edges and a stopped clock
`timescale 1ns/1ns
module dlmsc_clk_watch #(
  parameter int unsigned STOP_CYCLES = dlmsc_pkg::CLK_STOP_CYCLES
) (
  input logic clk_pin_in,
  dlmsc_clk_if.watch bus
);
  import dlmsc_pkg::*;
  localparam int unsigned W = $clog2(STOP_CYCLES + 1);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [W-1:0] idle;
    logic stopped;
    logic edge_seen;
  } dlmsc_watch_s;
  dlmsc_watch_s r;
  dlmsc_watch_s n;

  if (STOP_CYCLES < 2)
  begin : g_bad_stop
    $error("STOP_CYCLES too small");
  end

  always_comb
  begin
    n = r;
    n.s1 = clk_pin_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.edge_seen = r.s2 && !r.s3;
    // No level change for STOP_CYCLES means stopped
    if (r.s2 != r.s3)
    begin
      n.idle = '0;
      n.stopped = 1'b0;
    end
    else if (r.idle != W'(STOP_CYCLES))
      n.idle = r.idle + W'(1);
    else
      n.stopped = 1'b1;
  end

  always_ff @(posedge bus.clk)
  begin
    if (bus.rst)
    begin
      r <= '0;
      r.stopped <= 1'b1;
    end
    else
      r <= n;
  end

  assign bus.edge_seen = r.edge_seen;
  assign bus.stopped = r.stopped;
endmodule : dlmsc_clk_watch

/* src/dlmsc_keep_off.sv */
// Counts reference clock edges after a restart before the link may run
`timescale 1ns/1ns
module dlmsc_keep_off #(
  parameter int unsigned EDGES = dlmsc_pkg::KEEP_OFF_EDGES
) (
  dlmsc_clk_if.count bus
);
  import dlmsc_pkg::*;
  localparam int unsigned W = $clog2(EDGES + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic ready;
  } dlmsc_keep_s;
  dlmsc_keep_s r;
  dlmsc_keep_s n;

  if (EDGES < 1)
  begin : g_bad_edges
    $error("EDGES must be at least one");
  end

  always_comb
  begin
    n = r;
    if (bus.restart)
    begin
      n.cnt = '0;
      n.ready = 1'b0;
    end
    else if (bus.edge_seen && !r.ready)
    begin
      n.cnt = r.cnt + W'(1);
      n.ready = (r.cnt == W'(EDGES - 1));
    end
  end

  always_ff @(posedge bus.clk)
  begin
    if (bus.rst)
      r <= '0;
    else
      r <= n;
  end

  assign bus.ready = r.ready;
endmodule : dlmsc_keep_off

/* verification/dlmsc_far_model.sv */
// Far-side model: reference or link clock source and PLL lock
`timescale 1ns/1ns
module dlmsc_far_model #(
  parameter int HALF_NS = 160,
  parameter int LOCK_NS = 810
) (
  input wire logic run_in,
  input wire logic slow_in,
  input wire logic pll_en_in,
  output logic clk_out,
  output logic locked_out
);
  // Clock toggles only while running, parked low when stopped
  initial
  begin
    clk_out = 1'b0;
    #13;
    forever #HALF_NS clk_out = run_in ? ~clk_out : 1'b0;
  end
  // Lock only after enable and a settle time, dropped with enable
  initial
  begin
    locked_out = 1'b0;
    forever
    begin
      wait (pll_en_in === 1'b1);
      #(slow_in ? 10 * LOCK_NS : LOCK_NS);
      locked_out = pll_en_in;
      wait (pll_en_in !== 1'b1);
      locked_out = 1'b0;
    end
  end
endmodule : dlmsc_far_model

/* verification/display_link_mode_sleep_control_test.sv */
// Self-checking bench for the link mode and sleep controller
`timescale 1ns/1ns
module display_link_mode_sleep_control_test;
  import dlmsc_pkg::*;
  localparam int KO = 8;
  logic clk = 0, rst = 1, mss = 0, tm = 0, pd_n = 0, wo = 0, run = 0, slow = 0;
  logic cs1_n = 1, cs2_n = 1, wr_n = 1, rd_n = 1, rce = 0, rcol = 0, lce = 0;
  logic [1:0] pll = 2'h0, ods = 2'h3;
  logic [17:0] eng_d = 18'h00000;
  logic [5:0] eng = 6'h3E;
  logic role, test, sleep, ready, pll_en, fault, host_act, wr_req, rd_req, sub_sel, rd_ok;
  logic d_soft, s_soft, err, oe_n, m_n, s_n, w_n, r_n, cd, ref_clk, locked;
  logic [3:0] fac;
  logic [4:0] line;
  logic [17:0] dd;
  int fails = 0, cmp_count = 0, wr_cnt = 0, rd_cnt = 0, n = 0, ew = 0, er = 0;
  logic [1:0] hcs = 2'h3;
  always #20 clk = ~clk;
  always @(negedge clk)
  begin
    wr_cnt += (wr_req === 1'b1);
    rd_cnt += (rd_req === 1'b1);
  end
  dlmsc_far_model dlmsc_far_model_i (.run_in(run), .slow_in(slow), .pll_en_in(pll_en),
    .clk_out(ref_clk), .locked_out(locked));
  dlmsc_mode_sleep_ctrl #(.KEEP_OFF_EDGES(KO), .STOP_CYCLES(10)) dlmsc_mode_sleep_ctrl_i (
    .CLK_IN(clk), .RESET_IN(rst), .MASTER_SLAVE_SELECT_IN(mss), .FACTORY_TEST_SELECT_IN(tm),
    .PLL_MULTIPLIER_SELECT_IN(pll), .POWER_DOWN_N_IN(pd_n), .WRITE_ONLY_SELECT_IN(wo),
    .OUTPUT_DRIVE_SELECT_IN(ods), .REF_CLOCK_IN(ref_clk), .SERIAL_LINK_CLOCK_IN(ref_clk),
    .PLL_LOCKED_IN(locked), .HOST_MAIN_DISPLAY_SELECT_N_IN(cs1_n),
    .HOST_SUB_DISPLAY_SELECT_N_IN(cs2_n), .HOST_WRITE_N_IN(wr_n), .HOST_READ_N_IN(rd_n),
    .READ_CRC_ERROR_IN(rce), .READ_COLLECT_IN(rcol), .LINK_CRC_ERROR_IN(lce),
    .ENG_DATA_IN(eng_d), .ENG_DATA_RELEASE_IN(eng[0]), .ENG_MAIN_DISPLAY_SELECT_N_IN(eng[1]),
    .ENG_SUB_DISPLAY_SELECT_N_IN(eng[2]), .ENG_WRITE_N_IN(eng[3]), .ENG_READ_N_IN(eng[4]),
    .ENG_COMMAND_DATA_IN(eng[5]), .ROLE_MASTER_OUT(role), .TEST_MODE_OUT(test),
    .SLEEP_OUT(sleep), .LINK_READY_OUT(ready), .PLL_ENABLE_OUT(pll_en), .PLL_FACTOR_OUT(fac),
    .LINE_RATE_FACTOR_OUT(line), .CONFIG_FAULT_OUT(fault), .HOST_INPUTS_ACTIVE_OUT(host_act),
    .HOST_WRITE_REQ_OUT(wr_req), .HOST_READ_REQ_OUT(rd_req), .HOST_SUB_SELECT_OUT(sub_sel),
    .READ_PERMIT_OUT(rd_ok), .DATA_EDGE_SOFT_OUT(d_soft), .STROBE_EDGE_SOFT_OUT(s_soft),
    .ERROR_FLAG_OUT(err), .DISP_DATA_OUT(dd), .DISP_DATA_OE_N_OUT(oe_n),
    .DISP_MAIN_SELECT_N_OUT(m_n), .DISP_SUB_SELECT_N_OUT(s_n), .DISP_WRITE_N_OUT(w_n),
    .DISP_READ_N_OUT(r_n), .DISP_COMMAND_DATA_OUT(cd));

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Bounded wait for sleep (s=1) or link ready (s=0)
  task automatic wait_for(input logic s, input int lim);
    n = 0;
    while ((s ? sleep : ready) !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    chk(s ? "sleep_wait" : "ready_wait", 1, s ? sleep : ready);
    if ((s ? sleep : ready) !== 1'b1)
      end_sim;
  endtask : wait_for
  function automatic logic [3:0] exp_factor(input int c);
    return (c == 0) ? 4'h8 : (c == 1) ? 4'hA : 4'hC;
  endfunction : exp_factor
  task automatic start(input logic m, input logic t, input logic [1:0] c);
    rst = 1;
    mss = m;
    tm = t;
    pll = c;
    pd_n = 1;
    run = 1;
    tick(20);
    chk("reset_sleep", 1, sleep);
    chk("reset_pins", {7'h00, 18'h0, 7'h3E}, {dd, oe_n, m_n, s_n, w_n, r_n, cd, err});
    rst = 0;
    tick(8);
  endtask : start
  task automatic host(input logic [1:0] cs, input logic rd);
    {cs2_n, cs1_n} = cs;
    tick(1);
    if (rd) rd_n = 0;
    else wr_n = 0;
    tick(3);
    wr_n = 1;
    rd_n = 1;
    tick(3);
    cs1_n = 1;
    cs2_n = 1;
    tick(2);
  endtask : host

  initial
  begin
    void'($urandom(32'hB2611F5E));
    // Slave role
    start(0, 0, 2'h0);
    wait_for(0, 100);
    chk("slave_role", 0, role);
    chk("slave_pll", 0, {pll_en, fac});
    for (int i = 0; i < 8; i++)
    begin
      eng_d = 18'($urandom);
      eng = 6'($urandom);
      wo = 1'($urandom);
      ods = 2'($urandom);
      tick(5);
      chk("disp_ctl", {eng[5:1] | {1'b0, wo, 3'h0}}, {cd, r_n, w_n, s_n, m_n});
      chk("disp_oe_n", 1'(eng[0] & ~wo), oe_n);
      if (!eng[0] || wo) chk("disp_data", eng_d, dd);
      chk("read_permit", 1'(~wo), rd_ok);
      chk("edge_soft", 2'(~ods), {s_soft, d_soft});
    end
    lce = 1;
    tick(1);
    lce = 0;
    tick(3);
    chk("slave_err", 1, err);
    run = 0;
    wait_for(1, 40);
    chk("link_stop_err", 0, err);
    run = 1;
    wait_for(0, 100);
    chk("err_sticky", 1, err);
    pd_n = 0;
    tick(4);
    chk("pd_sleep", 1, sleep);
    chk("pd_pins", {18'h0, 7'h3E}, {dd, oe_n, m_n, s_n, w_n, r_n, cd, err});
    pd_n = 1;
    wait_for(0, 100);
    chk("err_cleared", 0, err);
    $display("slave test done");
    // Master role, each multiplier code
    for (int c = 0; c < 3; c++)
    begin
      slow = (c == 2);
      start(1, 0, c[1:0]);
      wait_for(0, 400);
      chk("keep_off", 1, n >= (slow ? 190 : 48));
      chk("master_role", 3'h7, {role, pll_en, host_act});
      chk("factor", exp_factor(c), fac);
      chk("line_rate", 2 * exp_factor(c), line);
      ew = wr_cnt;
      er = rd_cnt;
      for (int i = 0; i < 6; i++)
      begin
        hcs = 2'($urandom);
        host(hcs, i[0]);
        if (hcs != 2'h3 && i[0])
          er++;
        else if (hcs != 2'h3)
          ew++;
      end
      host(2'h3, 0);
      host(2'h2, 0);
      chk("main_select", 0, sub_sel);
      host(2'h1, 1);
      chk("sub_select", 1, sub_sel);
      chk("wr_pulses", ew + 1, wr_cnt);
      chk("rd_pulses", er + 1, rd_cnt);
      rce = 1;
      tick(1);
      rce = 0;
      tick(2);
      chk("read_err", 1, err);
      rcol = 1;
      tick(1);
      rcol = 0;
      tick(2);
      chk("read_err_clear", 0, err);
      rce = 1;
      tick(1);
      rce = 0;
      if (c == 1) pd_n = 0;
      else run = 0;
      wait_for(1, 40);
      tick(2);
      chk("sleep_pins", 0, {err, host_act, pll_en});
      pd_n = 1;
      run = 1;
      wait_for(0, 400);
      chk("rewake_keep_off", 1, n >= 48);
      $display("master test done");
    end
    start(1, 0, 2'h3);
    tick(40);
    chk("reserved_code", 4'hA, {fault, ready, sleep, pll_en});
    $display("reserved code test done");
    start(0, 1, 2'h0);
    tick(40);
    chk("test_mode", 2'h2, {test, ready});
    $display("test mode test done");
    end_sim;
  end
endmodule : display_link_mode_sleep_control_test
